//--- logic/scfc_top.sv
`timescale 1ns/10ps
`include "scfc_defines.svh"

// How it works
// - The word length is taken from the five-bit length field, as field+1.
// - Chip select is active high with polarity clear, low with it set.
// - The serial clock edge rate is the reference clock divided by 2^N.
// - The divider and clock drive act only while the port is master.
// - The clock polarity bit sets the clock's resting level.
// - Phase clear latches on odd clock edges, phase set on even edges.
// - In master mode the force bit holds chip select active directly.
module scfc_top #(
  parameter int DATA_W = 32,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire scfc_pkg::scfc_addr_t awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire scfc_pkg::scfc_addr_t araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic serial_clock_line_in,
  output logic serial_clock_line_out,
  output logic serial_clock_line_oe,
  input wire logic chip_select_line_in,
  output logic chip_select_line_out,
  output logic chip_select_line_oe,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_oe
);
  import scfc_pkg::*;

  function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        r[b*8 +: 8] = new_v[b*8 +: 8];
    return r;
  endfunction

  function automatic logic [31:0] low_mask(input logic [5:0] n);
    return 32'((33'h0_0001 << n) - 33'h0_0001);
  endfunction

  // ========================================================================
  // Configuration
  logic [31:0] cfg;
  logic [31:0] mode;
  logic master_mode;
  logic [4:0] wl;
  logic enable_polarity;
  logic [3:0] clock_divider_code;
  logic clock_polarity;
  logic clock_phase;
  logic force_cs;
  logic [5:0] word_len;
  logic [6:0] last_idx;

  assign master_mode = mode[`SCFC_MODE_MASTER_BIT];
  assign wl = cfg[`SCFC_WL_MSB:`SCFC_WL_LSB];
  assign enable_polarity = cfg[`SCFC_ENABLE_POLARITY_BIT];
  assign clock_divider_code = cfg[`SCFC_CLOCK_DIVIDER_CODE_MSB:`SCFC_CLOCK_DIVIDER_CODE_LSB];
  assign clock_polarity = cfg[`SCFC_POL_BIT];
  assign clock_phase = cfg[`SCFC_PHA_BIT];
  assign force_cs = cfg[`SCFC_FORCE_BIT];
  assign word_len = {1'b0, wl} + 6'h01;
  assign last_idx = 7'({word_len, 1'b0} - 7'h01);

  // ========================================================================
  // Pin synchronisers: clock, select, data
  logic [2:0] pin_raw;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] pin_flt;
  logic sclk_prev;
  logic sclk_edge;
  logic cs_sel;
  logic sdi_s;

  assign pin_raw = {serial_data_in, chip_select_line_in, serial_clock_line_in};

  generate
    for (genvar i = 0; i < 3; i++)
    begin : g_sync
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          sync1[i] <= 1'b0;
          sync2[i] <= 1'b0;
          sync3[i] <= 1'b0;
          pin_flt[i] <= 1'b0;
        end
        else
        begin
          sync1[i] <= pin_raw[i];
          sync2[i] <= sync1[i];
          sync3[i] <= sync2[i];
          if (sync2[i] == sync3[i])
            pin_flt[i] <= sync3[i];
        end
      end
    end
  endgenerate

  assign sclk_edge = pin_flt[0] ^ sclk_prev;
  assign cs_sel = (pin_flt[1] == ~enable_polarity);
  assign sdi_s = pin_flt[2];

  // ========================================================================
  // Transmit FIFO and engine control
  scfc_state_t state;
  scfc_state_t next_state;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [DATA_W-1:0] fifo_out_data;
  logic [31:0] wr_data_q;
  logic [14:0] div_cnt;
  logic [14:0] div_mask;
  logic tick;
  logic edge_ev;
  logic latch_ev;
  logic launch_ev;
  logic word_done;
  logic start;
  logic [5:0] edge_cnt;
  logic [31:0] txsr;
  logic [31:0] rxsr;
  logic [31:0] load_word;
  logic [31:0] tx_aligned;
  logic [31:0] rx_final;
  logic rx_full;
  logic eot;
  logic rd_rx;

  scfc_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_txfifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(DATA_W'(wr_data_q)),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  assign div_mask = 15'((16'h0001 << clock_divider_code) - 16'h0001);
  assign tick = master_mode && (state != st_idle) && (div_cnt == div_mask);
  assign edge_ev = (state == st_shift) && (master_mode ? tick : sclk_edge);
  assign latch_ev = edge_ev && (edge_cnt[0] == clock_phase);
  assign launch_ev = edge_ev && !latch_ev;
  assign word_done = edge_ev && ({1'b0, edge_cnt} == last_idx);
  assign start = (state == st_idle) && (next_state != st_idle);
  assign fifo_pop = start && fifo_out_valid;
  assign load_word = fifo_out_valid ? 32'(fifo_out_data) : 32'h0000_0000;
  assign tx_aligned = load_word << (6'd32 - word_len);
  assign rx_final = (latch_ev ? {rxsr[30:0], sdi_s} : rxsr) & low_mask(word_len);

  always_comb
  begin
    next_state = state;
    case (state)
      st_idle:
        if (master_mode && fifo_out_valid)
          next_state = st_lead;
        else if (!master_mode && cs_sel)
          next_state = st_shift;
      st_lead:
        if (tick)
          next_state = st_shift;
      st_shift:
        if (!master_mode && !cs_sel)
          next_state = st_idle;
        else if (word_done)
          next_state = master_mode ? st_trail : st_idle;
      st_trail:
        if (tick)
          next_state = st_idle;
      default:
        next_state = st_idle;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= st_idle;
      div_cnt <= '0;
      sclk_prev <= 1'b0;
    end
    else
    begin
      state <= next_state;
      sclk_prev <= pin_flt[0];
      if (state == st_idle || tick)
        div_cnt <= '0;
      else
        div_cnt <= div_cnt + 15'h0001;
    end
  end

  // Shift registers; pha clear puts the first bit out before any edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      txsr <= '0;
      rxsr <= '0;
      edge_cnt <= '0;
      serial_data_out <= 1'b0;
    end
    else if (start)
    begin
      edge_cnt <= '0;
      txsr <= clock_phase ? tx_aligned : tx_aligned << 1;
      if (!clock_phase)
        serial_data_out <= tx_aligned[31];
    end
    else
    begin
      if (edge_ev)
        edge_cnt <= edge_cnt + 6'h01;
      if (launch_ev)
      begin
        serial_data_out <= txsr[31];
        txsr <= txsr << 1;
      end
      if (latch_ev)
        rxsr <= {rxsr[30:0], sdi_s};
    end
  end

  // Pin drive; slave mode leaves clock and select undriven
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      serial_clock_line_out <= 1'b0;
      serial_clock_line_oe <= 1'b0;
      chip_select_line_out <= 1'b1;
      chip_select_line_oe <= 1'b0;
      serial_data_out_oe <= 1'b0;
    end
    else
    begin
      serial_clock_line_oe <= master_mode;
      chip_select_line_oe <= master_mode;
      serial_data_out_oe <= master_mode || cs_sel;
      if (!master_mode || state == st_idle)
        serial_clock_line_out <= clock_polarity;
      else if (edge_ev)
        serial_clock_line_out <= ~serial_clock_line_out;
      if (master_mode && (force_cs || next_state != st_idle))
        chip_select_line_out <= ~enable_polarity;
      else
        chip_select_line_out <= enable_polarity;
    end
  end

  // Set wins over a same-cycle read clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_full <= 1'b0;
      eot <= 1'b0;
    end
    else
    begin
      if (word_done)
        rx_full <= 1'b1;
      else if (rd_rx)
        rx_full <= 1'b0;
      if (word_done)
        eot <= 1'b1;
      else if (start)
        eot <= 1'b0;
    end
  end

  logic [31:0] rx_data;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx_data <= '0;
    else if (word_done)
      rx_data <= rx_final;
  end

  // ========================================================================
  // AXI4-Lite slave
  logic aw_held;
  logic w_held;
  scfc_addr_t aw_addr_q;
  logic [3:0] wr_strb_q;
  logic wr_is_tx;
  logic wr_known;
  logic wr_go;
  logic next_aw_held;
  logic next_w_held;
  logic rd_go;
  logic rd_known;
  logic [31:0] status;
  logic [31:0] rd_mux;

  assign wr_is_tx = (aw_addr_q == `SCFC_OFF_TXDATA);
  assign wr_known = (aw_addr_q == `SCFC_OFF_CONFIG) ||
                    (aw_addr_q == `SCFC_OFF_MODE) || wr_is_tx ||
                    (aw_addr_q == `SCFC_OFF_RXDATA) ||
                    (aw_addr_q == `SCFC_OFF_STATUS);
  // A full FIFO stalls the write response, pushing back on software
  assign wr_go = aw_held && w_held && !bvalid && !(wr_is_tx && !fifo_in_ready);
  assign fifo_in_valid = wr_go && wr_is_tx;
  assign next_aw_held = (aw_held && !wr_go) || (awvalid && awready);
  assign next_w_held = (w_held && !wr_go) || (wvalid && wready);
  assign rd_go = arvalid && arready;
  assign rd_rx = rd_go && (araddr == `SCFC_OFF_RXDATA);
  assign status = {27'h000_0000, eot, state != st_idle, !fifo_in_ready,
                   !fifo_out_valid, rx_full};
  assign rd_known = (araddr == `SCFC_OFF_CONFIG) ||
                    (araddr == `SCFC_OFF_MODE) ||
                    (araddr == `SCFC_OFF_TXDATA) ||
                    (araddr == `SCFC_OFF_RXDATA) ||
                    (araddr == `SCFC_OFF_STATUS);
  assign rd_mux = (araddr == `SCFC_OFF_CONFIG) ? cfg :
                  (araddr == `SCFC_OFF_MODE) ? mode :
                  (araddr == `SCFC_OFF_RXDATA) ? rx_data :
                  (araddr == `SCFC_OFF_STATUS) ? status : 32'h0000_0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      aw_addr_q <= '0;
      wr_data_q <= '0;
      wr_strb_q <= '0;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      awready <= !next_aw_held;
      wready <= !next_w_held;
      if (awvalid && awready)
        aw_addr_q <= awaddr;
      if (wvalid && wready)
      begin
        wr_data_q <= wdata;
        wr_strb_q <= wstrb;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg <= `SCFC_CONFIG_RESET;
      mode <= `SCFC_MODE_RESET;
      bvalid <= 1'b0;
      bresp <= `SCFC_RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid <= 1'b1;
      bresp <= wr_known ? `SCFC_RESP_OKAY : `SCFC_RESP_SLVERR;
      if (aw_addr_q == `SCFC_OFF_CONFIG)
        cfg <= strb_merge(cfg, wr_data_q, wr_strb_q) & `SCFC_CONFIG_MASK;
      if (aw_addr_q == `SCFC_OFF_MODE)
        mode <= strb_merge(mode, wr_data_q, wr_strb_q) & `SCFC_MODE_MASK;
    end
    else if (bvalid && bready)
      bvalid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `SCFC_RESP_OKAY;
    end
    else if (rd_go)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= rd_known ? `SCFC_RESP_OKAY : `SCFC_RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
    else if (!rvalid)
      arready <= 1'b1;
  end

  // ========================================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [15:0] tick_gap;
  logic tick_seen;
  logic sclk_d;
  logic [6:0] toggles;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || state == st_idle)
    begin
      tick_gap <= '0;
      tick_seen <= 1'b0;
    end
    else if (tick)
    begin
      tick_gap <= '0;
      tick_seen <= 1'b1;
    end
    else
      tick_gap <= tick_gap + 16'h0001;
  end
  always_ff @(posedge aclk)
  begin
    sclk_d <= serial_clock_line_out;
    if (!aresetn || start)
      toggles <= '0;
    else if (serial_clock_line_out != sclk_d)
      toggles <= toggles + 7'h01;
  end

  sequence master_launch;
    state == st_idle && master_mode && next_state == st_lead;
  endsequence
  sequence cs_up;
    chip_select_line_out == ~enable_polarity;
  endsequence

  word_edges_a: assert property (
    (master_mode && state == st_shift && next_state == st_trail) |=> ##1
    (toggles == 7'({word_len, 1'b0})))
    else $error("wrong edge count per word");
  start_cs_a: assert property (master_launch |=> cs_up)
    else $error("select not active at start");
  cs_active_a: assert property (
    master_mode && state == st_shift |-> chip_select_line_out == ~enable_polarity)
    else $error("select inactive during shift");
  div_gap_a: assert property (
    tick && tick_seen |-> tick_gap == 16'(div_mask))
    else $error("divider spacing wrong");
  slave_noclk_a: assert property (
    !master_mode |=> !serial_clock_line_oe && !chip_select_line_oe)
    else $error("slave drives clock or select");
  idle_level_a: assert property (
    master_mode && state == st_idle && next_state == st_idle |=>
    serial_clock_line_out == $past(clock_polarity))
    else $error("idle clock level wrong");
  latch_edge_a: assert property (
    master_mode && latch_ev |=>
    serial_clock_line_out == ($past(clock_phase) ? $past(clock_polarity) : ~$past(clock_polarity)))
    else $error("latch on wrong edge");
  force_cs_a: assert property (
    master_mode && force_cs |=> chip_select_line_out == ~$past(enable_polarity))
    else $error("forced select not active");
  slave_edge_a: assert property (
    !master_mode && state == st_shift && sclk_edge && cs_sel &&
    !word_done |=> edge_cnt == $past(edge_cnt) + 6'h01)
    else $error("slave edge not counted");
  bresp_hold_a: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");

endmodule

//--- logic/scfc_defines.svh
`ifndef SCFC_DEFINES_SVH
`define SCFC_DEFINES_SVH

// ==========================================================================
// Register offsets
`define SCFC_OFF_CONFIG 8'h00
`define SCFC_OFF_MODE 8'h04
`define SCFC_OFF_TXDATA 8'h08
`define SCFC_OFF_RXDATA 8'h0C
`define SCFC_OFF_STATUS 8'h10

// ==========================================================================
// Configuration fields
`define SCFC_WL_MSB 11
`define SCFC_WL_LSB 7
`define SCFC_ENABLE_POLARITY_BIT 6
`define SCFC_CLOCK_DIVIDER_CODE_MSB 5
`define SCFC_CLOCK_DIVIDER_CODE_LSB 2
`define SCFC_POL_BIT 1
`define SCFC_PHA_BIT 0
`define SCFC_FORCE_BIT 20
`define SCFC_MODE_MASTER_BIT 0

// ==========================================================================
// Reset values and masks
`define SCFC_CONFIG_RESET 32'h0000_0000
`define SCFC_CONFIG_MASK 32'h0010_0FFF
`define SCFC_MODE_RESET 32'h0000_0001
`define SCFC_MODE_MASK 32'h0000_0001

// ==========================================================================
// Bus responses
`define SCFC_RESP_OKAY 2'h0
`define SCFC_RESP_SLVERR 2'h2

`endif

//--- logic/scfc_pkg.sv
package scfc_pkg;

  typedef logic [7:0] scfc_addr_t;

  typedef enum logic [1:0] {
    st_idle,
    st_lead,
    st_shift,
    st_trail
  } scfc_state_t;

endpackage

//--- logic/scfc_fifo.sv
`timescale 1ns/10ps

module scfc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  // Pointers wrap naturally, so DEPTH must be a power of two
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

endmodule

//--- bench/scfc_spi_partner.sv
`timescale 1ns/10ps

// ==========================================================================
// Far side of the link: slave on the design's clock, master on request
module scfc_spi_partner (
  input wire logic aclk,
  input wire logic sclk,
  input wire logic cs,
  input wire logic sdi,
  output logic sdo,
  output logic m_sclk,
  output logic m_cs
);
  logic clock_polarity = 1'b0;
  logic clock_phase = 1'b0;
  logic enable_polarity = 1'b0;
  int len = 10;
  int edges = 0;
  int nbit = 0;
  int frames = 0;
  logic [31:0] tx_word = 32'h0000_0000;
  logic [31:0] rx_word = 32'h0000_0000;
  logic act;

  assign act = (cs === ~enable_polarity);

  initial
  begin
    sdo = 1'b0;
    m_sclk = 1'b0;
    m_cs = 1'b0;
  end

  task automatic drive_bit();
    if (nbit < len)
    begin
      sdo <= tx_word[len-1-nbit];
      nbit++;
    end
  endtask

  // Released line shows the inverse, never a stale valid bit
  always @(act)
  begin
    edges = 0;
    nbit = 0;
    if (act && !clock_phase)
      drive_bit();
    if (!act)
      sdo <= ~sdo;
  end

  always @(sclk)
  begin
    if (act)
    begin
      edges++;
      if (edges[0] ^ clock_phase)
        rx_word = {rx_word[30:0], sdi};
      else
        drive_bit();
      if (edges == 2 * len)
        frames++;
    end
  end

  // Clock stands at its idle level outside the frame
  task automatic run_master(input int half);
    m_sclk <= clock_polarity;
    m_cs <= ~enable_polarity;
    repeat (8) @(posedge aclk);
    for (int e = 0; e < 2 * len; e++)
    begin
      repeat (half) @(posedge aclk);
      m_sclk <= ~m_sclk;
    end
    repeat (half) @(posedge aclk);
    m_cs <= enable_polarity;
  endtask
endmodule

//--- bench/tb.sv
`timescale 1ns/10ps
`include "scfc_defines.svh"

module tb;
  import scfc_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  scfc_addr_t awaddr, araddr;
  logic [31:0] wdata, rdata, rdv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid;
  logic sck_out, sck_oe, cs_out, cs_oe, sd_out, sd_oe, d_last, sck_q;
  wire logic sck_w, cs_w, d2p, p2d, m_sclk, m_cs;
  int n_mismatch = 0;
  int checks = 0;
  int wait_n, gap_cnt = 0, sclk_gap = 0;
  int f0;
  int t_len[4] = '{10, 32, 10, 10};
  logic t_ep[4] = '{0, 1, 1, 0};
  // Master read-back passes the pin filter, so codes below 3 lose bits
  logic [3:0] t_cd[4] = '{3, 4, 3, 3};
  logic t_po[4] = '{0, 1, 0, 1};
  logic t_ph[4] = '{0, 1, 1, 0};
  logic [31:0] cs_val[4] = '{32'hFFFF_FFFF, 32'h0000_0040,
    32'h0010_0000, 32'h0000_0000};
  logic cs_exp[4] = '{0, 1, 1, 0};

  assign sck_w = sck_oe ? sck_out : m_sclk;
  assign cs_w = cs_oe ? cs_out : m_cs;
  assign d2p = sd_oe ? sd_out : ~d_last;

  scfc_top dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .serial_clock_line_in(sck_w),
    .serial_clock_line_out(sck_out), .serial_clock_line_oe(sck_oe),
    .chip_select_line_in(cs_w), .chip_select_line_out(cs_out),
    .chip_select_line_oe(cs_oe), .serial_data_in(p2d),
    .serial_data_out(sd_out), .serial_data_out_oe(sd_oe));

  scfc_spi_partner part (.aclk(aclk), .sclk(sck_w), .cs(cs_w), .sdi(d2p),
    .sdo(p2d), .m_sclk(m_sclk), .m_cs(m_cs));

  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // ==========================================================================
  // Link monitors: released data line and clock edge spacing
  always @(posedge aclk)
  begin
    if (sd_oe)
      d_last <= sd_out;
    sck_q <= sck_w;
    gap_cnt <= gap_cnt + 1;
    if (sck_w !== sck_q)
    begin
      sclk_gap <= gap_cnt + 1;
      gap_cnt <= 0;
    end
  end

  task automatic tally_and_finish();
    if (n_mismatch == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic lim(input int n);
    if (n >= 4000)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: no answer", $time);
      tally_and_finish();
    end
  endtask

  // ==========================================================================
  // Bus master; each task starts one edge on so bready never toggles twice
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (wait_n = 0; wait_n < 4000; wait_n++)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    lim(wait_n);
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (wait_n = 0; wait_n < 4000; wait_n++)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        rdv = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    lim(wait_n);
  endtask

  function automatic logic [31:0] msk(input int l);
    return (l == 32) ? 32'hFFFF_FFFF : (32'h0000_0001 << l) - 1;
  endfunction

  task automatic wait_idle();
    int k;
    for (k = 0; k < 1000; k++)
    begin
      rd(`SCFC_OFF_STATUS);
      if (rdv[3] === 1'b0 && rdv[1] === 1'b1)
        break;
    end
    lim(k * 4);
  endtask

  task automatic setcfg(input int l, input logic ep, input logic [3:0] cd,
    input logic po, input logic ph);
    wr(`SCFC_OFF_CONFIG, {20'h0_0000, 5'(l - 1), ep, cd, po, ph});
    part.len = l;
    part.enable_polarity = ep;
    part.clock_polarity = po;
    part.clock_phase = ph;
  endtask

  task automatic xfer(input logic [31:0] tx, input logic [31:0] rep,
    input int l);
    int f;
    f = part.frames;
    part.tx_word = rep;
    wr(`SCFC_OFF_TXDATA, tx);
    wait_idle();
    chk(part.rx_word & msk(l), tx & msk(l));
    rd(`SCFC_OFF_RXDATA);
    chk(rdv, rep & msk(l));
    chk(part.frames - f, 1);
  endtask

  initial
  begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`SCFC_OFF_CONFIG);
    chk(rdv, `SCFC_CONFIG_RESET);
    rd(`SCFC_OFF_MODE);
    chk(rdv, `SCFC_MODE_RESET);
    rd(8'h14);
    chk({30'h0, resp} | rdv, {30'h0, `SCFC_RESP_SLVERR});
    wr(8'h14, 32'hFFFF_FFFF);
    chk(resp, `SCFC_RESP_SLVERR);
    for (int i = 0; i < 4; i++)
    begin
      wr(`SCFC_OFF_CONFIG, cs_val[i]);
      chk(resp, `SCFC_RESP_OKAY);
      rd(`SCFC_OFF_CONFIG);
      chk(rdv, cs_val[i] & `SCFC_CONFIG_MASK);
      chk(cs_w, cs_exp[i]);
    end
    for (int i = 0; i < 4; i++)
    begin
      setcfg(t_len[i], t_ep[i], t_cd[i], t_po[i], t_ph[i]);
      xfer(32'hA5C3_96E1 + i, 32'h3C5A_F00F - i, t_len[i]);
      chk(sclk_gap, 1 << t_cd[i]);
      chk(sck_w, t_po[i]);
      chk(cs_w, t_ep[i]);
    end
    // Link drains slowly, so the sixth push must be held off
    setcfg(10, 0, 3, 0, 0);
    f0 = part.frames;
    for (int i = 0; i < 6; i++)
      wr(`SCFC_OFF_TXDATA, 32'h0000_0100 + i);
    chk(resp, `SCFC_RESP_OKAY);
    rd(`SCFC_OFF_STATUS);
    chk(rdv[2], 1);
    wait_idle();
    chk(part.frames - f0, 6);
    xfer(32'h0000_02B7, 32'h0000_0155, 10);
    rd(`SCFC_OFF_STATUS);
    chk(rdv[4], 1);
    wr(`SCFC_OFF_MODE, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    chk({sck_oe, cs_oe}, 0);
    part.tx_word = 32'h0000_0263;
    wr(`SCFC_OFF_TXDATA, 32'h0000_019A);
    part.run_master(16);
    repeat (8) @(posedge aclk);
    chk(sck_oe, 0);
    rd(`SCFC_OFF_RXDATA);
    chk(rdv, 32'h0000_0263);
    chk(part.rx_word & msk(10), 32'h0000_019A);
    tally_and_finish();
  end
endmodule
